//--- core/srs_seq.v
// Purpose: reference search sequencer of a servo positioning drive
// Assumes: object port writes and reads one word per strobe; pins asynchronous
// Notes:   drives speed and direction demands; trajectory lives elsewhere
`timescale 1ns/1ps
`include "srs_regs.vh"
module srs_seq (
   input  wire        i_clk_sys,
   input  wire        i_rst,
   input  wire        i_obj_wr,
   input  wire [15:0] i_obj_index,
   input  wire [7:0]  i_obj_sub,
   input  wire [31:0] i_obj_wdata,
   output reg  [31:0] o_obj_rdata,
   input  wire        i_lim_neg,
   input  wire        i_lim_pos,
   input  wire        i_enc_zero,
   input  wire        i_travel_fault,
   input  wire [15:0] i_load_integral,
   input  wire        i_pos_step,
   input  wire        i_pos_dir_neg,
   output reg         o_move_en,
   output reg         o_move_neg,
   output reg  [31:0] o_speed,
   output wire [31:0] o_ramp_rate,
   output wire [31:0] o_actual_pos,
   output wire        o_search_done,
   output wire        o_search_err
);
   ////////////////////////////////////////////////////////////////////////////
   // Object storage
   localparam [15:0] LOAD_LIMIT = `SRS_LOAD_FULL / 16'h0064 * `SRS_LOAD_PCT;
   localparam [3:0] ST_IDLE = 4'h0, ST_FAST = 4'h1, ST_SLOW_LS = 4'h2, ST_STOP = 4'h3,
                    ST_INDEX = 4'h4, ST_DONE = 4'h5, ST_ERR = 4'h6, ST_LATCH = 4'h7;
   reg        [31:0] zero_shift_reg;
   reg        [7:0]  method_reg;
   reg        [31:0] speed_reg [0:1];
   reg        [31:0] ramp_reg;
   reg        [7:0]  mode_reg;
   reg        [15:0] ctl_reg;
   reg        [31:0] pos_reg;
   reg        [3:0]  state_reg;
   reg        [1:0]  result_reg;
   reg               start_prev_reg;
   reg               dir_neg_reg;
   reg        [1:0]  dir_pipe_reg;
   wire [3:0] pin_sync;
   wire [3:0] pin_rise;
   wire [3:0] pin_fall;
   wire       lim_neg;
   wire       lim_pos;
   wire       idx_rise;
   wire       start_bit;
   wire       start_rise;
   wire       start_fall;
   wire       mode_ok;
   wire       halt;
   wire       wr_pos;

   function method_ok;
      input [7:0] m;
      begin
         method_ok = (m == `SRS_M_NEG_ZP) || (m == `SRS_M_POS_ZP) || (m == `SRS_M_NEG_LS) ||
                     (m == `SRS_M_POS_LS) || (m == `SRS_M_NEG_STOP_ZP) ||
                     (m == `SRS_M_POS_STOP_ZP) || (m == `SRS_M_NEG_IDX) ||
                     (m == `SRS_M_POS_IDX) || (m == `SRS_M_NO_RUN);
      end
   endfunction

   // Initial direction of the approach: negative methods
   function method_neg;
      input [7:0] m;
      begin
         method_neg = (m == `SRS_M_NEG_ZP) || (m == `SRS_M_NEG_LS) ||
                      (m == `SRS_M_NEG_STOP_ZP) || (m == `SRS_M_NEG_IDX);
      end
   endfunction

   srs_sync #(.W(4)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_async   ({i_pos_step, i_enc_zero, i_lim_pos, i_lim_neg}),
      .o_sync    (pin_sync)
   );

   srs_edge #(.W(4)) u_edge (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_lvl     (pin_sync),
      .o_rise    (pin_rise),
      .o_fall    (pin_fall)
   );

   // Synchronised limit switch levels and index rising edge
   assign lim_neg  = pin_sync[0];
   assign lim_pos  = pin_sync[1];
   assign idx_rise = pin_rise[2];

   ////////////////////////////////////////////////////////////////////////////
   // Object write port
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         zero_shift_reg <= `SRS_RST_ZERO_SHIFT;
         method_reg     <= `SRS_RST_METHOD;
         speed_reg[0]   <= `SRS_RST_SPEED_FAST;
         speed_reg[1]   <= `SRS_RST_SPEED_SLOW;
         ramp_reg       <= `SRS_RST_RAMP_RATE;
         mode_reg       <= 8'h00;
         ctl_reg        <= 16'h0000;
      end else if (i_obj_wr) begin
         case (i_obj_index)
            `SRS_ADDR_ZERO_SHIFT: zero_shift_reg <= i_obj_wdata;
            `SRS_ADDR_METHOD:     method_reg     <= i_obj_wdata[7:0];
            `SRS_ADDR_SPEED_PAIR: begin
               if (i_obj_sub == 8'h01) speed_reg[0] <= i_obj_wdata;
               if (i_obj_sub == 8'h02) speed_reg[1] <= i_obj_wdata;
            end
            `SRS_ADDR_RAMP_RATE:   ramp_reg <= i_obj_wdata;
            `SRS_ADDR_MODE_SELECT: mode_reg <= i_obj_wdata[7:0];
            `SRS_ADDR_CONTROL:     ctl_reg  <= i_obj_wdata[15:0];
            default: ;
         endcase
      end
   end

   assign start_bit  = ctl_reg[`SRS_CTL_START_BIT];
   assign halt       = ctl_reg[`SRS_CTL_HALT_BIT];
   assign mode_ok    = (mode_reg == `SRS_MODE_SEARCH);
   assign start_rise = start_bit & ~start_prev_reg;
   assign start_fall = ~start_bit & start_prev_reg;
   assign wr_pos     = i_obj_wr && (i_obj_index == `SRS_ADDR_ACTUAL_POS);

   ////////////////////////////////////////////////////////////////////////////
   // Search sequencer
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_reg      <= ST_IDLE;
         result_reg     <= 2'b00;
         start_prev_reg <= 1'b0;
         dir_neg_reg    <= 1'b0;
         dir_pipe_reg   <= 2'b00;
         pos_reg        <= 32'h00000000;
         o_move_en      <= 1'b0;
         o_move_neg     <= 1'b0;
         o_speed        <= 32'h00000000;
      end else begin
         start_prev_reg <= start_bit;
         if (wr_pos) begin
            pos_reg <= i_obj_wdata;
         end else if (pin_rise[3]) begin
            pos_reg <= dir_pipe_reg[1] ? pos_reg - 32'h1 : pos_reg + 32'h1;
         end
         // Step direction delayed to line up with the step synchroniser
         dir_pipe_reg <= {dir_pipe_reg[0], i_pos_dir_neg};
         case (state_reg)
            ST_IDLE, ST_DONE: begin
               o_move_en <= 1'b0;
               if (start_rise && mode_ok) begin
                  result_reg  <= 2'b00;
                  dir_neg_reg <= method_neg(method_reg);
                  o_move_neg  <= method_neg(method_reg);
                  if (!method_ok(method_reg)) begin
                     state_reg <= ST_ERR;
                  end else if (method_reg == `SRS_M_NO_RUN) begin
                     state_reg <= ST_LATCH;
                  end else if (method_reg == `SRS_M_NEG_IDX || method_reg == `SRS_M_POS_IDX) begin
                     state_reg <= ST_INDEX;
                     o_speed   <= speed_reg[1];
                     o_move_en <= 1'b1;
                  end else if (method_reg == `SRS_M_NEG_STOP_ZP || method_reg == `SRS_M_POS_STOP_ZP) begin
                     state_reg <= ST_STOP;
                     o_speed   <= speed_reg[0];
                     o_move_en <= 1'b1;
                  end else begin
                     state_reg <= ST_FAST;
                     o_speed   <= speed_reg[0];
                     o_move_en <= 1'b1;
                  end
               end
            end
            ST_FAST: begin
               if ((dir_neg_reg && lim_neg) || (!dir_neg_reg && lim_pos)) begin
                  dir_neg_reg <= ~dir_neg_reg;
                  o_move_neg  <= ~dir_neg_reg;
                  o_speed     <= speed_reg[1];
                  state_reg   <= ST_SLOW_LS;
               end
            end
            ST_SLOW_LS: begin
               if ((method_reg == `SRS_M_NEG_LS && pin_fall[0]) ||
                   (method_reg == `SRS_M_POS_LS && pin_fall[1])) begin
                  state_reg <= ST_LATCH;
               end else if ((method_reg == `SRS_M_NEG_ZP && pin_fall[0]) ||
                            (method_reg == `SRS_M_POS_ZP && pin_fall[1])) begin
                  state_reg <= ST_INDEX;
               end
            end
            ST_STOP: begin
               if (i_load_integral >= LOAD_LIMIT) begin
                  dir_neg_reg <= ~dir_neg_reg;
                  o_move_neg  <= ~dir_neg_reg;
                  o_speed     <= speed_reg[1];
                  state_reg   <= ST_INDEX;
               end
            end
            ST_INDEX: begin
               if (idx_rise) state_reg <= ST_LATCH;
            end
            ST_LATCH: begin
               o_move_en  <= 1'b0;
               pos_reg    <= zero_shift_reg;
               result_reg <= 2'b01;
               state_reg  <= ST_DONE;
            end
            ST_ERR: begin
               o_move_en  <= 1'b0;
               result_reg <= 2'b10;
               state_reg  <= ST_DONE;
            end
            default: state_reg <= ST_IDLE;
         endcase
         if (state_reg == ST_FAST || state_reg == ST_SLOW_LS || state_reg == ST_STOP ||
             state_reg == ST_INDEX) begin
            if (halt || (lim_neg && lim_pos) || i_travel_fault || !mode_ok) begin
               state_reg <= ST_ERR;
               o_move_en <= 1'b0;
            end else if (start_fall) begin
               state_reg <= ST_IDLE;
               o_move_en <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Object read port
   // Result code never 11
   assign o_search_done = result_reg == 2'b01;
   assign o_search_err  = result_reg == 2'b10;
   assign o_ramp_rate   = ramp_reg;
   assign o_actual_pos  = pos_reg;

   always @* begin
      case (i_obj_index)
         `SRS_ADDR_ZERO_SHIFT:  o_obj_rdata = zero_shift_reg;
         `SRS_ADDR_METHOD:      o_obj_rdata = {{24{method_reg[7]}}, method_reg};
         `SRS_ADDR_SPEED_PAIR:  o_obj_rdata = (i_obj_sub == 8'h02) ? speed_reg[1] :
                                             (i_obj_sub == 8'h01) ? speed_reg[0] : 32'h00000002;
         `SRS_ADDR_RAMP_RATE:   o_obj_rdata = ramp_reg;
         `SRS_ADDR_MODE_SELECT: o_obj_rdata = {24'h000000, mode_reg};
         `SRS_ADDR_CONTROL:     o_obj_rdata = {16'h0000, ctl_reg};
         `SRS_ADDR_STATUS:      o_obj_rdata = {16'h0000, 2'h0, o_search_err, o_search_done, 12'h000};
         `SRS_ADDR_ACTUAL_POS:  o_obj_rdata = pos_reg;
         default:               o_obj_rdata = 32'h00000000;
      endcase
   end
endmodule // srs_seq

//--- core/srs_regs.vh
// Purpose: constants for the reference search sequencer
// Assumes: object indices are used as register addresses
// Notes:   one 32-bit data word per object access
`ifndef SRS_REGS_VH
`define SRS_REGS_VH
// Object addresses
`define SRS_ADDR_ZERO_SHIFT   16'h607C
`define SRS_ADDR_METHOD       16'h6098
`define SRS_ADDR_SPEED_PAIR   16'h6099
`define SRS_ADDR_RAMP_RATE    16'h609A
`define SRS_ADDR_MODE_SELECT  16'h6060
`define SRS_ADDR_CONTROL      16'h6040
`define SRS_ADDR_STATUS       16'h6041
`define SRS_ADDR_ACTUAL_POS   16'h6064
// Reset values
`define SRS_RST_ZERO_SHIFT    32'h00000000
`define SRS_RST_METHOD        8'h11
`define SRS_RST_SPEED_FAST    32'h00000064
`define SRS_RST_SPEED_SLOW    32'h0000000A
`define SRS_RST_RAMP_RATE     32'h000000FA
// Field positions
`define SRS_CTL_START_BIT     4
`define SRS_CTL_HALT_BIT      8
`define SRS_STS_DONE_BIT      12
`define SRS_STS_ERR_BIT       13
// Mode and method codes
`define SRS_MODE_SEARCH       8'h06
`define SRS_M_NEG_ZP          8'h01
`define SRS_M_POS_ZP          8'h02
`define SRS_M_NEG_LS          8'h11
`define SRS_M_POS_LS          8'h12
`define SRS_M_NEG_STOP_ZP     8'hFF
`define SRS_M_POS_STOP_ZP     8'hFE
`define SRS_M_NEG_IDX         8'h21
`define SRS_M_POS_IDX         8'h22
`define SRS_M_NO_RUN          8'h23
// Load limit: 90 percent of full scale 16-bit load integral
`define SRS_LOAD_PCT          16'h005A
`define SRS_LOAD_FULL         16'hFFFF
`endif

//--- core/srs_sync.v
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   first stage read only by second stage
`timescale 1ns/1ps
module srs_sync #(
   parameter W = 4
) (
   input  wire         i_clk_sys,
   input  wire         i_rst,
   input  wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end
   assign o_sync = sync_reg;
endmodule // srs_sync

//--- core/srs_edge.v
// Purpose: rising and falling edge pulses of synchronised levels
// Assumes: inputs already synchronous
// Notes:   one-cycle pulses
`timescale 1ns/1ps
module srs_edge #(
   parameter W = 4
) (
   input  wire         i_clk_sys,
   input  wire         i_rst,
   input  wire [W-1:0] i_lvl,
   output wire [W-1:0] o_rise,
   output wire [W-1:0] o_fall
);
   reg [W-1:0] prev_reg;
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         prev_reg <= {W{1'b0}};
      end else begin
         prev_reg <= i_lvl;
      end
   end
   assign o_rise = i_lvl & ~prev_reg;
   assign o_fall = ~i_lvl & prev_reg;
endmodule // srs_edge

//--- dv/srs_seq_assertions.sv
// Purpose: port-level checks of the reference search sequencer
// Assumes: one clock, reset asynchronous and active high
// Notes:   bound to every sequencer instance
`timescale 1ns/1ps
module srs_seq_assertions (
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   input wire logic        i_obj_wr,
   input wire logic [15:0] i_obj_index,
   input wire logic [31:0] i_obj_wdata,
   input wire logic [31:0] o_obj_rdata,
   input wire logic        i_lim_neg,
   input wire logic        i_lim_pos,
   input wire logic        i_travel_fault,
   input wire logic        o_move_en,
   input wire logic [31:0] o_ramp_rate,
   input wire logic        o_search_done,
   input wire logic        o_search_err
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   sequence move_start; !o_move_en ##1 o_move_en; endsequence
   sequence both_hit; (o_move_en && i_lim_neg && i_lim_pos) [*2]; endsequence
   sequence ramp_wr; i_obj_wr && i_obj_index == 16'h609A; endsequence
   status_legal_a: assert property (!(o_search_done && o_search_err))
      else $error("status bits both set");
   done_hold_a: assert property (o_search_done && !i_obj_wr && !$past(i_obj_wr) |=> o_search_done)
      else $error("done dropped without write");
   err_hold_a: assert property (o_search_err && !i_obj_wr && !$past(i_obj_wr) |=> o_search_err)
      else $error("error dropped without write");
   start_clears_a: assert property (move_start |-> !o_search_done && !o_search_err)
      else $error("status not clear at motion start");
   stop_on_done_a: assert property ($rose(o_search_done) |-> ##[0:1] !o_move_en)
      else $error("motion after done");
   ramp_write_a: assert property (ramp_wr |=> o_ramp_rate == $past(i_obj_wdata))
      else $error("ramp rate not written");
   ramp_read_a: assert property (!i_obj_wr && i_obj_index == 16'h609A |-> o_obj_rdata == o_ramp_rate)
      else $error("ramp read mismatch");
   status_read_a: assert property (i_obj_index == 16'h6041 |->
      o_obj_rdata[13:12] == {o_search_err, o_search_done})
      else $error("status read mismatch");
   travel_err_a: assert property (o_move_en && i_travel_fault |-> ##[1:4] o_search_err)
      else $error("no error on travel fault");
   both_sw_err_a: assert property (both_hit |-> ##[0:6] o_search_err)
      else $error("no error on both switches");
endmodule // srs_seq_assertions
bind srs_seq srs_seq_assertions srs_seq_assertions_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_obj_wr(i_obj_wr),
   .i_obj_index(i_obj_index), .i_obj_wdata(i_obj_wdata), .o_obj_rdata(o_obj_rdata), .i_lim_neg(i_lim_neg),
   .i_lim_pos(i_lim_pos), .i_travel_fault(i_travel_fault), .o_move_en(o_move_en), .o_ramp_rate(o_ramp_rate),
   .o_search_done(o_search_done), .o_search_err(o_search_err));

//--- dv/srs_axis_model.sv
// Purpose: axis with limit switches, end stops and encoder index
// Assumes: one position step every fourth cycle of motion
// Notes:   switches beyond +-40, stops at +-60, index every 16 steps
`timescale 1ns/1ps
module srs_axis_model (
   input  wire logic        i_clk_sys,
   input  wire logic        i_move_en,
   input  wire logic        i_move_neg,
   input  wire logic        i_jam,
   output logic             o_lim_neg,
   output logic             o_lim_pos,
   output logic             o_enc_zero,
   output logic             o_pos_step,
   output logic             o_dir_neg,
   output logic [15:0]      o_load
);
   int pos = 0;
   int div = 0;
   initial {o_lim_neg, o_lim_pos, o_enc_zero, o_pos_step, o_dir_neg, o_load} = '0;
   always @(posedge i_clk_sys) begin
      #1;
      o_pos_step = 1'b0;
      o_dir_neg = i_move_neg;
      if (i_move_en === 1'b1) begin
         div = div + 1;
         if (div == 4) begin
            div = 0;
            if (i_move_neg ? pos > -60 : pos < 60) begin
               pos = pos + (i_move_neg ? -1 : 1);
               o_pos_step = 1'b1;
            end
         end
      end
      o_load = (i_move_en && (i_move_neg ? pos <= -60 : pos >= 60)) ? 16'hF000 : 16'h0100;
      o_lim_neg = (pos < -40) || i_jam;
      o_lim_pos = (pos > 40) || i_jam;
      o_enc_zero = (pos % 16) == 0;
   end
endmodule // srs_axis_model

//--- dv/srs_seq_tb_top.sv
// Purpose: self-checking bench of the reference search sequencer
// Assumes: axis model answers the pins
// Notes:   expected values from a per-method table
`timescale 1ns/1ps
module srs_seq_tb_top;
   logic        i_clk_sys = 0, i_rst = 1, i_obj_wr = 0, i_travel_fault = 0;
   logic [15:0] i_obj_index = 0;
   logic [7:0]  i_obj_sub = 0;
   logic [31:0] i_obj_wdata = 0;
   wire  [31:0] o_obj_rdata, o_speed, o_ramp_rate, o_actual_pos;
   wire  [15:0] load;
   wire         lim_n, lim_p, enc_z, step, dir_n, o_move_en, o_move_neg, o_search_done, o_search_err;
   int          num_errors = 0, n_tests = 0;
   bit   [31:0] rng = 32'h99a4e69e;
   bit          moved;
   bit   [31:0] rr, spd0;
   bit          dir0;
   logic        jam = 0;
   always #12.5 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) begin
      if (o_move_en === 1'b1) begin
         if (!moved) begin
            spd0 = o_speed;
            dir0 = o_move_neg;
         end
         moved = 1;
      end
   end
   srs_seq srs_seq_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_obj_wr(i_obj_wr), .i_obj_index(i_obj_index),
      .i_obj_sub(i_obj_sub), .i_obj_wdata(i_obj_wdata), .o_obj_rdata(o_obj_rdata), .i_lim_neg(lim_n),
      .i_lim_pos(lim_p), .i_enc_zero(enc_z), .i_travel_fault(i_travel_fault), .i_load_integral(load),
      .i_pos_step(step), .i_pos_dir_neg(dir_n), .o_move_en(o_move_en), .o_move_neg(o_move_neg),
      .o_speed(o_speed), .o_ramp_rate(o_ramp_rate), .o_actual_pos(o_actual_pos),
      .o_search_done(o_search_done), .o_search_err(o_search_err));
   srs_axis_model srs_axis_model_i (.i_clk_sys(i_clk_sys), .i_move_en(o_move_en), .i_move_neg(o_move_neg),
      .o_lim_neg(lim_n), .o_lim_pos(lim_p), .o_enc_zero(enc_z), .o_pos_step(step), .o_dir_neg(dir_n),
      .o_load(load), .i_jam(jam));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic bit [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   task automatic chk(input bit ok, input string msg);
      n_tests++;
      if (!ok) begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask
   task automatic wr(input [15:0] a, input [7:0] s, input [31:0] d);
      @(posedge i_clk_sys);
      #1 {i_obj_wr, i_obj_index, i_obj_sub, i_obj_wdata} = {1'b1, a, s, d};
      @(posedge i_clk_sys);
      #1 i_obj_wr = 0;
   endtask
   task automatic rd(input [15:0] a, input [7:0] s, input [31:0] e);
      @(posedge i_clk_sys);
      #1 {i_obj_index, i_obj_sub} = {a, s};
      #2 chk(o_obj_rdata === e, "read value");
   endtask
   task automatic waitend(input int n);
      repeat (3) @(posedge i_clk_sys);
      for (int k = 0; k < n && o_search_done !== 1'b1 && o_search_err !== 1'b1; k++) @(posedge i_clk_sys);
      repeat (3) @(posedge i_clk_sys);
      #2;
   endtask
   // Runs one search with a random shift; status, motion and origin against the table
   task automatic run(input [7:0] m, input [1:0] st, input bit mv);
      bit [31:0] sh;
      sh = xs();
      wr(16'h607C, 0, sh);
      wr(16'h6098, 0, {24'h0, m});
      wr(16'h6040, 0, 0);
      moved = 0;
      wr(16'h6040, 0, 32'h10);
      waitend(3000);
      chk({o_search_err, o_search_done} === st, "status pair");
      chk(moved === mv, "motion");
      if (st == 2'b01) chk(o_actual_pos === sh, "origin");
      chk(o_move_en === 1'b0, "stopped");
      if (mv) chk(spd0 === ((m == 8'h21 || m == 8'h22) ? 32'h0A : 32'h64), "search speed");
      if (mv) chk(o_speed === 32'h0A, "slow speed");
      if (mv) chk(dir0 === (m == 8'h01 || m == 8'h11 || m == 8'hFF || m == 8'h21), "direction");
      rd(16'h6041, 0, {18'h0, st, 12'h0});
      $display("test method %0h ended", m);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge i_clk_sys);
      #1 i_rst = 0;
      rd(16'h607C, 0, 32'h0);
      rd(16'h6098, 0, 32'h11);
      rd(16'h6099, 0, 32'h2);
      rd(16'h6099, 1, 32'h64);
      rd(16'h6099, 2, 32'h0A);
      rd(16'h609A, 0, 32'hFA);
      rd(16'h1234, 0, 32'h0);
      wr(16'h6098, 0, 32'hFF);
      rd(16'h6098, 0, 32'hFFFFFFFF);
      rr = xs();
      wr(16'h609A, 0, rr);
      rd(16'h609A, 0, rr);
      $display("test registers ended");
      run(8'h11, 2'b00, 1'b0);
      wr(16'h6060, 0, 32'h6);
      run(8'h11, 2'b01, 1'b1);
      run(8'h01, 2'b01, 1'b1);
      run(8'h02, 2'b01, 1'b1);
      run(8'h12, 2'b01, 1'b1);
      run(8'hFF, 2'b01, 1'b1);
      run(8'hFE, 2'b01, 1'b1);
      run(8'h21, 2'b01, 1'b1);
      run(8'h22, 2'b01, 1'b1);
      run(8'h23, 2'b01, 1'b0);
      run(8'h05, 2'b10, 1'b0);
      wr(16'h6098, 0, 32'h11);
      wr(16'h6040, 0, 0);
      wr(16'h6040, 0, 32'h10);
      repeat (40) @(posedge i_clk_sys);
      wr(16'h6040, 0, 0);
      repeat (6) @(posedge i_clk_sys);
      #2 chk({o_search_err, o_search_done, o_move_en} === 3'b000, "abort");
      wr(16'h6040, 0, 32'h10);
      repeat (40) @(posedge i_clk_sys);
      wr(16'h6040, 0, 32'h110);
      waitend(50);
      chk({o_search_err, o_search_done} === 2'b10, "halt");
      wr(16'h6040, 0, 0);
      wr(16'h6040, 0, 32'h10);
      repeat (40) @(posedge i_clk_sys);
      #1 i_travel_fault = 1;
      repeat (4) @(posedge i_clk_sys);
      #1 i_travel_fault = 0;
      waitend(50);
      chk({o_search_err, o_search_done} === 2'b10, "travel fault");
      wr(16'h6040, 0, 0);
      wr(16'h6040, 0, 32'h10);
      repeat (40) @(posedge i_clk_sys);
      #1 jam = 1;
      repeat (4) @(posedge i_clk_sys);
      #1 jam = 0;
      waitend(50);
      chk({o_search_err, o_search_done} === 2'b10, "both switches");
      $display("test errors ended");
      close_out();
   end
endmodule // srs_seq_tb_top
